// ==== dv/watchdog_cause_flag_asserts.sv ====
// concurrent checks on the ports of the watchdog and reset-flag block
`timescale 1ns/1ps
module watchdog_cause_flag_asserts
  import watchdog_cause_flag_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_PERIOD_CYCLES,
  parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic restartReq,
  input wire watchdog_cause_flag_src_t resetSrc,
  input wire logic wdogPulse,
  input wire logic chipResetActive
);
  localparam int MinGap = (BASE_CYCLES - 1) * OSC_DIV;
  // wide enough for the full-size period and time-out counts
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;
  logic [31:0] gap_q;
  logic [31:0] gap_d;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // cycles with no reset cause, cycles since the count was cleared
  always_comb
  begin
    quiet_d = (resetSrc != 5'h00 || wdogPulse) ? 32'h00000000 : quiet_q + 32'(quiet_q != 32'hffffffff);
    gap_d = (restartReq || chipResetActive) ? 32'h00000000 : gap_q + 32'(gap_q != 32'hffffffff);
  end
  always_ff @(posedge core_clk)
  begin
    quiet_q <= nrst ? quiet_d : 32'h00000000;
    gap_q <= nrst ? gap_d : 32'h00000000;
  end
  sequence statusRead;
    regRd && regAddr == ADDR_RESET_CAUSE;
  endsequence
  sequence causeClear;
    regWr && regAddr == ADDR_RESET_CAUSE && resetSrc == 5'h00 && !wdogPulse;
  endsequence
  // ==========================================================
  // checks
  pulse_one_cycle_a: assert property (wdogPulse |=> !wdogPulse)
    else $error("watchdog pulse too long");
  pulse_then_reset_a: assert property (wdogPulse |=> chipResetActive)
    else $error("no reset after watchdog pulse");
  source_holds_reset_a: assert property (resetSrc != 5'h00 |=> chipResetActive)
    else $error("reset source without internal reset");
  delay_length_a: assert property ($fell(chipResetActive) |-> quiet_q >= 32'(TIMEOUT_CYCLES))
    else $error("internal reset released early");
  ctrl_rsvd_zero_a: assert property (regRd && regAddr == ADDR_WDOG_CTRL |=> regRdata[7:5] == 3'h0)
    else $error("reserved control bits not zero");
  ext_flag_set_a: assert property (resetSrc.external ##1 (resetSrc.external ##0 statusRead) |=> regRdata[1])
    else $error("external flag not set");
  wd_flag_set_a: assert property (resetSrc.watchdog ##1 (resetSrc.watchdog ##0 statusRead) |=> regRdata[3])
    else $error("watchdog flag not set");
  restart_gap_a: assert property (wdogPulse |-> gap_q >= 32'(MinGap))
    else $error("expiry too soon after restart");
  delay_bound_a: assert property (chipResetActive |-> quiet_q <= 32'(TIMEOUT_CYCLES))
    else $error("internal reset held too long");
  flag_clear_a: assert property (causeClear ##1 (resetSrc == 5'h00 && !wdogPulse) ##1 statusRead |=>
    (regRdata[4:0] & ~$past(regWdata[4:0], 3)) == 5'h00)
    else $error("zero write did not clear flag");
endmodule // watchdog_cause_flag_asserts

bind watchdog_cause_flag_top watchdog_cause_flag_asserts #(.BASE_CYCLES(BASE_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_watchdog_cause_flag_asserts (
  .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .restartReq(restartReq), .resetSrc(resetSrc),
  .wdogPulse(wdogPulse), .chipResetActive(chipResetActive));

// ==== dv/watchdog_cause_flag_bench.sv ====
// self-checking bench for the watchdog and reset-flag block
`timescale 1ns/1ps
module watchdog_cause_flag_bench
  import watchdog_cause_flag_pkg::*;
;
  localparam int Base = 4;
  localparam int Tmo = 8;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic restartReq = 1'b0;
  watchdog_cause_flag_src_t resetSrc = 5'h00;
  logic [7:0] regRdata;
  logic wdogPulse;
  logic chipResetActive;
  logic [7:0] flags = 8'h00;
  logic [7:0] rd;
  logic [7:0] w;
  logic [4:0] s;
  int error_cnt = 0;
  int comparisons = 0;
  int pulses = 0;
  int n;

  watchdog_cause_flag_top #(.BASE_CYCLES(Base), .TIMEOUT_CYCLES(Tmo)) u_watchdog_cause_flag_top (
    .core_clk(core_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .restartReq(restartReq), .resetSrc(resetSrc),
    .wdogPulse(wdogPulse), .chipResetActive(chipResetActive));

  initial
  begin
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (wdogPulse === 1'b1) pulses++;

  // ==========================================================
  // bus tasks and comparison
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task automatic rdreg(input logic [3:0] a);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 rd = regRdata;
  endtask
  // sampled on the falling edge so the rising-edge updates have landed
  task automatic settle();
    n = 0;
    while (chipResetActive !== 1'b0 && n < 100)
    begin
      @(negedge core_clk);
      n++;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #400us;
    error_cnt++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    complete_run();
  end

  // ==========================================================
  // tests
  initial
  begin
    void'($urandom(67));
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    settle();
    rdreg(ADDR_RESET_CAUSE);
    check(rd, 8'h00);
    rdreg(4'hf);
    check(rd, 8'h00);
    $display("test reset done");
    // powerOn is driven alone: its clearing of the other flags must not race a set
    for (int i = 0; i < 8; i++)
    begin
      s = (i % 5 == 0) ? 5'h01 : ((5'($urandom()) & 5'h1e) | (5'h01 << (i % 5)));
      flags = s[0] ? 8'h01 : (flags | {3'h0, s});
      @(posedge core_clk);
      resetSrc <= s;
      rdreg(ADDR_RESET_CAUSE);
      check(rd, flags);
      @(posedge core_clk);
      resetSrc <= 5'h00;
      settle();
      w = 8'($urandom());
      flags = flags & w;
      wr(ADDR_RESET_CAUSE, w);
      rdreg(ADDR_RESET_CAUSE);
      check(rd, flags);
    end
    $display("test flags done");
    // a held restart keeps the count clear through the control register writes and reads
    @(posedge core_clk);
    restartReq <= 1'b1;
    wr(ADDR_WDOG_CTRL, 8'hff);
    rdreg(ADDR_WDOG_CTRL);
    check(rd, 8'h1f);
    repeat (4) @(posedge core_clk);
    rdreg(ADDR_WDOG_CTRL);
    check(rd, 8'h0f);
    wr(ADDR_WDOG_CTRL, 8'h02);
    rdreg(ADDR_WDOG_CTRL);
    check(rd, 8'h0a);
    wr(ADDR_WDOG_CTRL, 8'h18);
    repeat (6) @(posedge core_clk);
    wr(ADDR_WDOG_CTRL, 8'h00);
    rdreg(ADDR_WDOG_CTRL);
    check(rd, 8'h08);
    wr(ADDR_WDOG_CTRL, 8'h18);
    wr(ADDR_WDOG_CTRL, 8'h00);
    rdreg(ADDR_WDOG_CTRL);
    // enable is already off while the turn-off bit still stands in its window
    check(rd, 8'h10);
    restartReq <= 1'b0;
    repeat (300) @(posedge core_clk);
    check(8'(pulses), 8'h00);
    wr(ADDR_WDOG_CTRL, 8'h08);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge core_clk);
      restartReq <= 1'b1;
      @(posedge core_clk);
      restartReq <= 1'b0;
      repeat (60) @(posedge core_clk);
    end
    check(8'(pulses), 8'h00);
    $display("test control done");
    for (int p = 0; p < 3; p++)
    begin
      @(posedge core_clk);
      restartReq <= 1'b1;
      wr(ADDR_WDOG_CTRL, 8'h08 | 8'(p));
      restartReq <= 1'b0;
      n = 0;
      while (wdogPulse !== 1'b1 && n < 2000)
      begin
        @(negedge core_clk);
        n++;
      end
      check(8'(n >= ((Base << p) - 1) * OSC_DIV && n <= ((Base << p) + 3) * OSC_DIV), 8'h01);
      @(negedge core_clk);
      check({6'h00, wdogPulse, chipResetActive}, 8'h01);
      settle();
      check(8'(n >= Tmo - 1 && n <= Tmo + 2), 8'h01);
      flags = flags | 8'h08;
      rdreg(ADDR_RESET_CAUSE);
      check(rd, flags);
      rdreg(ADDR_WDOG_CTRL);
      check(rd, 8'h00);
    end
    $display("test expiry done");
    complete_run();
  end
endmodule // watchdog_cause_flag_bench

// ==== hw/watchdog_cause_flag_top.sv ====
// watchdog timer with reset-cause flags and reset stretching
`timescale 1ns/1ps
module watchdog_cause_flag_top
  import watchdog_cause_flag_pkg::*;
#(
  parameter int BASE_CYCLES = BASE_PERIOD_CYCLES,
  parameter int TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES
)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic restartReq,
  input wire watchdog_cause_flag_src_t resetSrc,
  output logic wdogPulse,
  output logic chipResetActive
);

  localparam int CNT_W = 32;

  // ==========================================================
  // elaboration checks
  generate
    if (BASE_CYCLES < 2 || TIMEOUT_CYCLES < 1)
    begin : g_bad_count
      $error("watchdog_cause_flag_top: period or time-out count out of range");
    end
    // the longest period is the base shifted by seven and has to fit the counter
    if (BASE_CYCLES > 32'h01ffffff)
    begin : g_bad_base
      $error("watchdog_cause_flag_top: base period too long for the counter");
    end
    // the tick divider counts in eight bits
    if (OSC_DIV < 2 || OSC_DIV > 256)
    begin : g_bad_div
      $error("watchdog_cause_flag_top: oscillator divider out of range");
    end
  endgenerate

  function automatic logic [CNT_W-1:0] periodLimit(input logic [PERIOD_W-1:0] code);
    periodLimit = CNT_W'(BASE_CYCLES) << code;
  endfunction

  // ==========================================================
  // oscillator tick divider
  // one clock only, so the 1 MHz watchdog oscillator is a tick enable
  logic [7:0] divCnt_q, divCnt_d;
  logic oscTick;

  always_comb
  begin
    oscTick = (divCnt_q == 8'(OSC_DIV - 1));
    divCnt_d = oscTick ? 8'h00 : divCnt_q + 8'h01;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      divCnt_q <= 8'h00;
    else
      divCnt_q <= divCnt_d;
  end

  // ==========================================================
  // watchdog control register
  // internal reset turns the watchdog off again, as any chip reset must
  logic enable_q, enable_d;
  logic turnOff_q, turnOff_d;
  logic [PERIOD_W-1:0] period_q, period_d;
  logic [2:0] toCnt_q, toCnt_d;
  logic ctrlWr, causeWr;

  always_comb
  begin
    ctrlWr = regWr && (regAddr == ADDR_WDOG_CTRL);
    causeWr = regWr && (regAddr == ADDR_RESET_CAUSE);
    enable_d = enable_q;
    turnOff_d = turnOff_q;
    period_d = period_q;
    toCnt_d = toCnt_q;
    if (turnOff_q)
    begin
      toCnt_d = toCnt_q - 3'h1;
      if (toCnt_q == 3'h1)
        turnOff_d = 1'b0;
    end
    if (ctrlWr)
    begin
      period_d = regWdata[PERIOD_LSB +: PERIOD_W];
      if (regWdata[BIT_ENABLE])
        enable_d = 1'b1;
      else if (turnOff_q)
        enable_d = 1'b0;
      if (regWdata[BIT_TURN_OFF])
      begin
        turnOff_d = 1'b1;
        toCnt_d = 3'(TURN_OFF_CYCLES);
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || chipResetActive)
    begin
      enable_q <= WDOG_CTRL_RST[BIT_ENABLE];
      turnOff_q <= WDOG_CTRL_RST[BIT_TURN_OFF];
      period_q <= WDOG_CTRL_RST[PERIOD_LSB +: PERIOD_W];
      toCnt_q <= 3'h0;
    end
    else
    begin
      enable_q <= enable_d;
      turnOff_q <= turnOff_d;
      period_q <= period_d;
      toCnt_q <= toCnt_d;
    end
  end

  // ==========================================================
  // watchdog counter
  // settings cross only at a tick, so a restart acts up to one tick late and a disable up to two ticks late
  logic oscEnable_q, oscEnable_d;
  logic [PERIOD_W-1:0] oscPeriod_q, oscPeriod_d;
  logic restartPend_q, restartPend_d;
  logic [CNT_W-1:0] wdCnt_q, wdCnt_d;
  logic pulse_d;

  always_comb
  begin
    oscEnable_d = oscEnable_q;
    oscPeriod_d = oscPeriod_q;
    restartPend_d = restartPend_q | restartReq;
    wdCnt_d = wdCnt_q;
    pulse_d = 1'b0;
    if (oscTick)
    begin
      // settings and restart sampled on tick
      oscEnable_d = enable_q;
      oscPeriod_d = period_q;
      restartPend_d = restartReq;
      if (restartPend_q || !oscEnable_q)
        wdCnt_d = '0;
      else if (wdCnt_q >= periodLimit(oscPeriod_q) - CNT_W'(1))
      begin
        wdCnt_d = '0;
        pulse_d = 1'b1;
      end
      else
        wdCnt_d = wdCnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst || chipResetActive)
    begin
      oscEnable_q <= 1'b0;
      oscPeriod_q <= '0;
      restartPend_q <= 1'b0;
      wdCnt_q <= '0;
      wdogPulse <= 1'b0;
    end
    else
    begin
      oscEnable_q <= oscEnable_d;
      oscPeriod_q <= oscPeriod_d;
      restartPend_q <= restartPend_d;
      wdCnt_q <= wdCnt_d;
      wdogPulse <= pulse_d;
    end
  end

  // ==========================================================
  // reset sequencer
  // every nrst release also passes through the time-out before the block runs
  watchdog_cause_flag_seq_t seq_q, seq_d;
  logic [CNT_W-1:0] dly_q, dly_d;
  logic anySrc;

  always_comb
  begin
    anySrc = (|resetSrc) | wdogPulse;
    seq_d = seq_q;
    dly_d = dly_q;
    unique case (seq_q)
      SEQ_RUN:
        if (anySrc)
          seq_d = SEQ_HOLD;
      SEQ_HOLD:
        if (!anySrc)
        begin
          seq_d = SEQ_DELAY;
          dly_d = '0;
        end
      SEQ_DELAY:
        if (anySrc)
          seq_d = SEQ_HOLD;
        else if (dly_q == CNT_W'(TIMEOUT_CYCLES - 1))
          seq_d = SEQ_RUN;
        else
          dly_d = dly_q + CNT_W'(1);
      default:
        seq_d = SEQ_HOLD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      seq_q <= SEQ_HOLD;
      dly_q <= '0;
    end
    else
    begin
      seq_q <= seq_d;
      dly_q <= dly_d;
    end
  end

  assign chipResetActive = (seq_q != SEQ_RUN);

  // ==========================================================
  // reset cause flags
  // nrst or a write of zero clears every flag; a power-on source clears the others but keeps bit 0 set
  logic [4:0] flags_q, flags_d;
  logic [4:0] setMask;

  always_comb
  begin
    setMask = '0;
    setMask[BIT_POWER_ON] = resetSrc.powerOn;
    setMask[BIT_EXTERNAL] = resetSrc.external;
    setMask[BIT_BROWNOUT] = resetSrc.brownout;
    setMask[BIT_WATCHDOG] = resetSrc.watchdog | wdogPulse;
    setMask[BIT_TEST_PORT] = resetSrc.testPort;
    flags_d = flags_q;
    if (causeWr)
      flags_d = flags_q & regWdata[4:0];
    if (resetSrc.powerOn)
      flags_d = '0;
    // cause flags set
    // a set in the same cycle as a clearing write wins
    flags_d = flags_d | setMask;
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      flags_q <= RESET_CAUSE_RST[4:0];
    else
      flags_q <= flags_d;
  end

  // ==========================================================
  // read port
  // idle cycles and unmapped addresses read zero, so data stands one cycle only
  logic [7:0] rdata_d;

  always_comb
  begin
    rdata_d = 8'h00;
    if (regRd)
    begin
      if (regAddr == ADDR_RESET_CAUSE)
        rdata_d = {3'h0, flags_q};
      else if (regAddr == ADDR_WDOG_CTRL)
        rdata_d = {3'h0, turnOff_q, enable_q, period_q};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
      regRdata <= 8'h00;
    else
      regRdata <= rdata_d;
  end

endmodule // watchdog_cause_flag_top

// ==== inc/watchdog_cause_flag_pkg.sv ====
// constants and types shared by the watchdog and reset-flag block
package watchdog_cause_flag_pkg;

  // ==========================================================
  // register map
  localparam logic [3:0] ADDR_RESET_CAUSE = 4'h0;
  localparam logic [3:0] ADDR_WDOG_CTRL = 4'h1;

  // ==========================================================
  // field positions
  localparam int BIT_POWER_ON = 0;
  localparam int BIT_EXTERNAL = 1;
  localparam int BIT_BROWNOUT = 2;
  localparam int BIT_WATCHDOG = 3;
  localparam int BIT_TEST_PORT = 4;
  localparam int BIT_ENABLE = 3;
  localparam int BIT_TURN_OFF = 4;
  localparam int PERIOD_LSB = 0;
  localparam int PERIOD_W = 3;

  // ==========================================================
  // reset values
  localparam logic [7:0] RESET_CAUSE_RST = 8'h00;
  localparam logic [7:0] WDOG_CTRL_RST = 8'h00;

  // ==========================================================
  // timing
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int WDOG_OSC_HZ = 1_000_000;
  localparam int OSC_DIV = SYS_CLK_HZ / WDOG_OSC_HZ;
  localparam int TURN_OFF_CYCLES = 4;
  localparam int BASE_PERIOD_CYCLES = 16384;
  localparam int RESET_TIMEOUT_CYCLES = 65536;

  // ==========================================================
  // types
  typedef struct packed {
    logic testPort;
    logic watchdog;
    logic brownout;
    logic external;
    logic powerOn;
  } watchdog_cause_flag_src_t;

  typedef enum logic [1:0] {
    SEQ_RUN = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_DELAY = 2'b10
  } watchdog_cause_flag_seq_t;

endpackage
